/* File: hw/led_mode_power_ctl.sv */
// Mode, slow clock, sync pin and power save control of the three-channel LED engine.
//
// Contract
// - Aux output pin follows its register bit.
// - Stop instruction with irq field raises irq.
// - Irq pin push-pull output or open-drain interrupt.
// - Accept sync low of two slow ticks.
// - Drive sync pulse low three slow ticks.
// - Slow clock from oscillator or outside pin.
// - Auto select falls back when outside clock dies.
// - Report clock source in use.
// - No clock detection during power save.
// - Reset key or supply clear restores defaults.
// - Power pin low: shutdown, clear active, PCs.
// - Standby ignores run control writes until active bit set.
// - Active bit starts; thermal cutout reenters startup.
// - Clearing active bit resets program counters.
// - Power save only when auto sleep allowed.
// - Power save domains depend on clock source.
// - Sleep only when all channels idle long.
// - Execution continues; wake on PWM command.
// - Upload, nonzero PWM, fixed pump gain block sleep.
// - Long waits, ramps, sets qualify.
// - Sync waits and qualifying stops also qualify.
// - Channel modes resynchronised to slow clock.
// - Disabled channel: zero current, PC reset.
`timescale 1ns/10ps
`default_nettype none
module led_mode_power_ctl
	import led_pwr_pkg::*;
#(
	parameter int STARTUP_CYC = 64,
	parameter int EXT_GAP = EXT_GAP_CYC,
	parameter int IDLE_LIMIT = IDLE_TICKS
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic supply_up_clear_i,
	input wire logic chip_power_pin_i,
	input wire logic thermal_cutout_i,
	input wire logic reset_wr_i,
	input wire logic [7:0] reset_wdata_i,
	input wire logic active_wr_i,
	input wire logic active_wdata_i,
	input wire logic run_ctl_wr_i,
	input wire logic [5:0] run_ctl_wdata_i,
	input wire logic [5:0] channel_behaviour_reg_i,
	input wire logic onchip_osc_select_i,
	input wire logic clock_watch_on_i,
	input wire logic auto_sleep_allow_i,
	input wire logic [1:0] pump_mode_i,
	input wire logic aux_output_bit_i,
	input wire logic irq_out_bit_i,
	input wire logic irq_pin_as_output_i,
	input wire logic [NCH-1:0] stop_irq_i,
	input wire logic irq_clear_i,
	input wire chan_look_s [NCH-1:0] look_i,
	input wire logic sync_send_i,
	input wire logic sync_pulse_pin_i,
	input wire logic slow_ref_clock_pin_i,
	output logic aux_output_o,
	output logic irq_line_o,
	output logic irq_line_oe_o,
	output logic sync_pulse_pin_o,
	output logic sync_pulse_pin_oe_o,
	output logic sync_seen_o,
	output logic slow_tick_o,
	output logic outside_clock_active_flag_o,
	output logic device_active_bit_o,
	output logic [5:0] run_ctl_o,
	output logic [5:0] mode_slow_o,
	output logic [NCH-1:0] pc_clear_o,
	output logic [NCH-1:0] chan_current_on_o,
	output logic regs_default_o,
	output logic bus_enabled_o,
	output logic power_save_o,
	output power_ctl_s power_o,
	output dev_state_e state_o
);
	initial begin
		if (STARTUP_CYC < 1 || STARTUP_CYC > 255) $error("STARTUP_CYC out of range");
		if (EXT_GAP < 2 || EXT_GAP >= (1 << GAP_W)) $error("EXT_GAP out of range");
		if (IDLE_LIMIT < 1 || IDLE_LIMIT >= (1 << IDLE_W)) $error("IDLE_LIMIT out of range");
	end

	// ============================================================
	// Pin synchronisers
	// ============================================================
	logic sync_in_lvl, ext_clk_lvl;

	pin_sync3 #(.RESET_VAL(1'b1)) u_sync_in (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.pin_i(sync_pulse_pin_i),
		.level_o(sync_in_lvl)
	);

	pin_sync3 #(.RESET_VAL(1'b0)) u_ext_clk (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.pin_i(slow_ref_clock_pin_i),
		.level_o(ext_clk_lvl)
	);

	// ============================================================
	// State
	// ============================================================
	typedef struct packed {
		dev_state_e st;
		logic active;
		logic [5:0] run_ctl;
		logic [5:0] mode_meta;
		logic [5:0] mode_slow;
		logic [7:0] start_cnt;
		logic [DIV_W-1:0] osc_cnt;
		logic ext_prev;
		logic [GAP_W-1:0] gap_cnt;
		logic ext_present;
		logic use_ext;
		logic tick;
		logic [TICK_W-1:0] sin_cnt;
		logic sin_armed;
		logic seen;
		logic [TICK_W-1:0] sout_cnt;
		logic sout_on;
		logic sout_wait;
		logic [IDLE_W-1:0] idle_cnt;
		logic irq;
		logic [NCH-1:0] pc_clr;
	} ctl_state_s;

	ctl_state_s s_q, s_d;

	function automatic logic chan_may_sleep(input chan_look_s l, input logic [1:0] mode);
		logic ok;
		ok = l.wait_long | l.ramp_to_zero | l.set_zero_then_wait;
		ok = ok | (l.sync_wait & l.pwm_zero) | (l.stop_cmd & (l.pwm_zero | l.stop_reset));
		return (mode == MODE_DISABLED) | (ok & l.pwm_zero & ~l.needs_pwm);
	endfunction

	logic shutdown, soft_reset, all_idle, blocked, ext_edge, irq_set;

	always_comb begin
		s_d = s_q;
		shutdown = ~chip_power_pin_i;
		soft_reset = reset_wr_i & (reset_wdata_i == RESET_KEY);
		all_idle = 1'b1;
		blocked = ~((pump_mode_i == CP_OFF) | (pump_mode_i == CP_AUTO));
		for (int c = 0; c < NCH; c++) begin
			all_idle = all_idle & chan_may_sleep(look_i[c], s_q.mode_slow[2*c+:2]);
			blocked = blocked | (s_q.mode_slow[2*c+:2] == MODE_LOAD);
		end
		ext_edge = ext_clk_lvl ^ s_q.ext_prev;
		irq_set = |stop_irq_i;
		s_d.ext_prev = ext_clk_lvl;
		s_d.pc_clr = '0;
		s_d.tick = 1'b0;

		// Slow clock: internal divider and outside clock watch.
		if (s_q.osc_cnt == DIV_W'(OSC_DIV - 1)) begin
			s_d.osc_cnt = '0;
		end else begin
			s_d.osc_cnt = s_q.osc_cnt + 1'b1;
		end
		if (s_q.st != ST_SAVE) begin
			if (ext_edge) begin
				s_d.gap_cnt = '0;
				s_d.ext_present = 1'b1;
			end else if (s_q.gap_cnt == GAP_W'(EXT_GAP)) begin
				s_d.ext_present = 1'b0;
			end else begin
				s_d.gap_cnt = s_q.gap_cnt + 1'b1;
			end
		end
		if (clock_watch_on_i) begin
			s_d.use_ext = s_q.ext_present;
		end else begin
			s_d.use_ext = ~onchip_osc_select_i;
		end
		s_d.tick = s_q.use_ext ? (ext_edge & ext_clk_lvl) : (s_q.osc_cnt == '0);

		// Channel modes cross into the slow tick domain in two steps.
		if (s_q.tick) begin
			s_d.mode_meta = channel_behaviour_reg_i;
			s_d.mode_slow = s_q.mode_meta;
		end
		for (int c = 0; c < NCH; c++) begin
			if (s_q.mode_slow[2*c+:2] == MODE_DISABLED) begin
				s_d.pc_clr[c] = 1'b1;
			end
		end

		// Incoming sync pulse, measured in slow ticks.
		if (sync_in_lvl | s_q.sout_on) begin
			s_d.sin_cnt = '0;
			s_d.sin_armed = 1'b1;
		end else if (s_q.tick && s_q.sin_cnt != TICK_W'(SYNC_IN_TICKS)) begin
			s_d.sin_cnt = s_q.sin_cnt + 1'b1;
		end
		s_d.seen = 1'b0;
		if (s_q.sin_armed && s_q.sin_cnt == TICK_W'(SYNC_IN_TICKS)) begin
			s_d.seen = 1'b1;
			s_d.sin_armed = 1'b0;
		end

		// Outgoing sync pulse, started and ended on slow ticks so it spans whole periods.
		if (sync_send_i && !s_q.sout_on && !s_q.sout_wait) begin
			s_d.sout_wait = 1'b1;
		end else if (s_q.sout_wait && s_q.tick) begin
			s_d.sout_wait = 1'b0;
			s_d.sout_on = 1'b1;
			s_d.sout_cnt = '0;
		end else if (s_q.sout_on && s_q.tick) begin
			if (s_q.sout_cnt == TICK_W'(SYNC_OUT_TICKS - 1)) begin
				s_d.sout_on = 1'b0;
			end else begin
				s_d.sout_cnt = s_q.sout_cnt + 1'b1;
			end
		end

		// Interrupt latch, set wins over clear.
		if (irq_set) begin
			s_d.irq = 1'b1;
		end else if (irq_clear_i) begin
			s_d.irq = 1'b0;
		end

		// Idle counter on the selected slow clock.
		if (!all_idle || blocked) begin
			s_d.idle_cnt = '0;
		end else if (s_q.tick && s_q.idle_cnt != IDLE_W'(IDLE_LIMIT)) begin
			s_d.idle_cnt = s_q.idle_cnt + 1'b1;
		end

		// Device state machine.
		if (active_wr_i) begin
			s_d.active = active_wdata_i;
			if (!active_wdata_i) begin
				s_d.pc_clr = '1;
			end
		end
		if (run_ctl_wr_i && s_q.active) begin
			s_d.run_ctl = run_ctl_wdata_i;
		end
		unique case (s_q.st)
			ST_RESET: begin
				s_d.st = ST_STANDBY;
			end
			ST_STANDBY: begin
				s_d.start_cnt = '0;
				if (s_d.active && !thermal_cutout_i) begin
					s_d.st = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				if (thermal_cutout_i) begin
					s_d.start_cnt = '0;
				end else if (s_q.start_cnt == 8'(STARTUP_CYC - 1)) begin
					s_d.st = ST_NORMAL;
				end else begin
					s_d.start_cnt = s_q.start_cnt + 1'b1;
				end
			end
			ST_NORMAL: begin
				if (thermal_cutout_i) begin
					s_d.st = ST_STARTUP;
					s_d.start_cnt = '0;
				end else if (auto_sleep_allow_i && !blocked && all_idle
						&& s_q.idle_cnt == IDLE_W'(IDLE_LIMIT)) begin
					s_d.st = ST_SAVE;
				end
			end
			ST_SAVE: begin
				if (thermal_cutout_i) begin
					s_d.st = ST_STARTUP;
					s_d.start_cnt = '0;
				end else if (!auto_sleep_allow_i || blocked || !all_idle) begin
					s_d.st = ST_NORMAL;
				end
			end
		endcase
		if (!s_d.active && s_q.st != ST_RESET) begin
			s_d.st = ST_STANDBY;
		end

		if (shutdown) begin
			s_d.active = 1'b0;
			s_d.pc_clr = '1;
			s_d.st = ST_STANDBY;
			s_d.sout_on = 1'b0;
			s_d.sout_wait = 1'b0;
		end
		if (soft_reset || supply_up_clear_i) begin
			s_d = '0;
			s_d.st = ST_RESET;
			s_d.ext_prev = ext_clk_lvl;
			s_d.pc_clr = '1;
			s_d.sin_armed = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '{st: ST_RESET, sin_armed: 1'b1, pc_clr: '1, default: '0};
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// ============================================================
	// Outputs
	// ============================================================
	assign aux_output_o = aux_output_bit_i;
	assign irq_line_o = irq_pin_as_output_i ? irq_out_bit_i : 1'b0;
	assign irq_line_oe_o = chip_power_pin_i & (irq_pin_as_output_i | s_q.irq);
	assign sync_pulse_pin_o = 1'b0;
	assign sync_pulse_pin_oe_o = s_q.sout_on;
	assign sync_seen_o = s_q.seen;
	assign slow_tick_o = s_q.tick;
	assign outside_clock_active_flag_o = s_q.use_ext;
	assign device_active_bit_o = s_q.active;
	assign run_ctl_o = s_q.run_ctl;
	assign mode_slow_o = s_q.mode_slow;
	assign pc_clear_o = s_q.pc_clr;
	assign state_o = s_q.st;
	assign regs_default_o = (s_q.st == ST_RESET);
	assign bus_enabled_o = chip_power_pin_i;
	assign power_save_o = (s_q.st == ST_SAVE);
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			chan_current_on_o[c] = (s_q.st == ST_NORMAL)
				&& (s_q.mode_slow[2*c+:2] != MODE_DISABLED);
		end
		power_o = '0;
		power_o.pump_protect = (s_q.st == ST_SAVE);
		if (s_q.st == ST_NORMAL) begin
			power_o = '{analog_on: 1'b1, osc_on: 1'b1, pump_on: 1'b1,
				drivers_on: 1'b1, pump_protect: 1'b1};
		end else if (s_q.st == ST_SAVE) begin
			power_o.osc_on = ~s_q.use_ext;
			power_o.analog_on = ~s_q.use_ext;
		end else if (s_q.st == ST_STARTUP) begin
			power_o.analog_on = 1'b1;
			power_o.osc_on = 1'b1;
		end
	end

	// ============================================================
	// Checks
	// ============================================================
	logic sout_cut;

	assign sout_cut = shutdown | soft_reset | supply_up_clear_i;

	sequence sout_start;
		$rose(sync_pulse_pin_oe_o);
	endsequence

	sequence sout_end;
		$fell(sync_pulse_pin_oe_o) && !$past(sout_cut);
	endsequence

	sync_out_start_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		sout_start |-> $past(slow_tick_o))
		else $error("sync pulse output started off a slow tick");
	sync_out_end_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		sout_end |-> $past(slow_tick_o))
		else $error("sync pulse output ended off a slow tick");
	sleep_allow_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		$rose(power_save_o) |-> $past(auto_sleep_allow_i))
		else $error("power save entered while not allowed");
	sleep_block_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(ce_i && power_save_o && blocked && !shutdown && !soft_reset && !supply_up_clear_i)
		|=> !power_save_o)
		else $error("power save kept while blocked");
	shutdown_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(ce_i && shutdown) |=> !device_active_bit_o && (&pc_clear_o))
		else $error("shutdown did not clear active bit and counters");
	soft_reset_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(ce_i && soft_reset) |=> state_o == ST_RESET && !device_active_bit_o)
		else $error("reset key did not reset");
	flag_source_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(ce_i && !clock_watch_on_i && $stable(onchip_osc_select_i) && !soft_reset
		&& !supply_up_clear_i) |=>
		outside_clock_active_flag_o == !$past(onchip_osc_select_i))
		else $error("clock source flag wrong in manual select");
	irq_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(ce_i && irq_set && !soft_reset && !supply_up_clear_i) |=> s_q.irq)
		else $error("stop interrupt not latched");
	disabled_off_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(mode_slow_o[1:0] == MODE_DISABLED) |-> !chan_current_on_o[0])
		else $error("disabled channel drives current");
	thermal_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(ce_i && thermal_cutout_i && state_o == ST_NORMAL && chip_power_pin_i
		&& !soft_reset && !supply_up_clear_i && device_active_bit_o && !active_wr_i)
		|=> state_o == ST_STARTUP)
		else $error("thermal cutout did not reenter startup");
endmodule
`default_nettype wire

/* File: hw/led_pwr_pkg.sv */
// Package with constants, states and carrier structs for the LED engine mode and power control.
package led_pwr_pkg;

	// ============================================================
	// Timing
	// ============================================================
	localparam int SYS_CLK_HZ = 100000000;
	localparam int SLOW_CLK_HZ = 32768;
	localparam int IDLE_MS = 50;
	// Idle threshold in slow-clock ticks (rounded up).
	localparam int IDLE_TICKS = (IDLE_MS * SLOW_CLK_HZ + 999) / 1000;
	localparam int IDLE_W = 12;
	localparam int MIN_EXT_HZ = 15000;
	// Longest gap between outside clock edges: half the slowest period, in system cycles.
	localparam int EXT_GAP_CYC = SYS_CLK_HZ / (2 * MIN_EXT_HZ);
	localparam int GAP_W = 14;
	localparam int SYNC_IN_TICKS = 2;
	localparam int SYNC_OUT_TICKS = 3;
	localparam int TICK_W = 2;
	// Internal oscillator tick period in system cycles.
	localparam int OSC_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;
	localparam int DIV_W = 12;

	// ============================================================
	// Codes and widths
	// ============================================================
	localparam int NCH = 3;
	localparam int PC_W = 4;
	localparam logic [7:0] RESET_KEY = 8'hff;
	localparam logic [1:0] MODE_DISABLED = 2'h0;
	localparam logic [1:0] MODE_LOAD = 2'h1;
	localparam logic [1:0] CP_OFF = 2'h0;
	localparam logic [1:0] CP_AUTO = 2'h3;

	// ============================================================
	// Device states
	// ============================================================
	typedef enum logic [4:0] {
		ST_RESET = 5'h01,
		ST_STANDBY = 5'h02,
		ST_STARTUP = 5'h04,
		ST_NORMAL = 5'h08,
		ST_SAVE = 5'h10
	} dev_state_e;

	// Per-channel look-ahead report from the instruction engine.
	typedef struct packed {
		logic pwm_zero;
		logic wait_long;
		logic ramp_to_zero;
		logic set_zero_then_wait;
		logic sync_wait;
		logic stop_cmd;
		logic stop_reset;
		logic needs_pwm;
	} chan_look_s;

	// Power domain controls.
	typedef struct packed {
		logic analog_on;
		logic osc_on;
		logic pump_on;
		logic drivers_on;
		logic pump_protect;
	} power_ctl_s;
endpackage

/* File: hw/pin_sync3.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/10ps
`default_nettype none
module pin_sync3
	import led_pwr_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic pin_i,
	output logic level_o
);
	typedef struct packed {
		logic [2:0] ff;
		logic lvl;
	} sync_state_s;

	sync_state_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.ff = {s_q.ff[1:0], pin_i};
		// Only the second and third stages are compared; the first only shifts into the second.
		if (s_q.ff[1] == s_q.ff[2]) begin
			s_d.lvl = s_q.ff[2];
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '{ff: {3{RESET_VAL}}, lvl: RESET_VAL};
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign level_o = s_q.lvl;
endmodule
`default_nettype wire

/* File: testbench/sync_peer_model.sv */
// Peer device model: outside slow clock source and open-drain sync line driver.
`timescale 1ns/10ps
`default_nettype none
module sync_peer_model #(
	parameter int HALF = 20
) (
	input wire logic clk_sys_i,
	input wire logic run_clk_i,
	input wire logic pull_req_i,
	input wire logic [3:0] pull_len_i,
	output logic ref_clk_o,
	output logic pull_low_o
);
	int half_q = 0;
	int left_q = 0;
	initial ref_clk_o = 1'b0;
	initial pull_low_o = 1'b0;
	// The clock holds its level when stopped, so the device sees it stuck.
	always @(posedge clk_sys_i) begin
		if (run_clk_i) begin
			half_q <= (half_q == HALF - 1) ? 0 : half_q + 1;
			if (half_q == HALF - 1) ref_clk_o <= ~ref_clk_o;
		end
	end
	// The line is held low from the request until the pull_len_i-th falling edge of its own clock.
	always @(posedge clk_sys_i) begin
		if (pull_req_i) begin
			left_q <= pull_len_i;
			pull_low_o <= 1'b1;
		end else if (run_clk_i && half_q == HALF - 1 && ref_clk_o && left_q > 0) begin
			left_q <= left_q - 1;
			if (left_q == 1) pull_low_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/test_led_mode_power_ctl.sv */
// Self-checking testbench of the LED engine mode and power control.
`timescale 1ns/10ps
`default_nettype none
module test_led_mode_power_ctl;
	import led_pwr_pkg::*;
	// ============================================================
	// Signals
	// ============================================================
	logic clk_sys_i = 0, nrst_i = 0, ce_i = 1, supply_up_clear = 0, pwr_pin = 1, thermal = 0;
	logic reset_wr = 0, active_wr = 0, active_wd = 0, run_wr = 0, osc_sel = 1;
	logic watch = 0, allow = 0, aux_bit = 0, irq_bit = 0, irq_gpo = 0, irq_clr = 0;
	logic sync_send = 0, run_clk = 0, pull_req = 0, sync_line, ref_clk, peer_low;
	logic [7:0] reset_wd = 0;
	logic [5:0] run_wd = 0, beh = 6'h2a;
	logic [1:0] pump = 0;
	logic [NCH-1:0] stop_irq = 0;
	logic [3:0] pull_len = 0;
	chan_look_s [NCH-1:0] look = '0;
	chan_look_s idle;
	logic aux_o, irq_o, irq_oe, sp_o, sp_oe, seen, tick, ext_flag, active;
	logic bus_en, save, regs_def;
	logic [5:0] run_o, mode_o;
	logic [NCH-1:0] pc_clr, cur_on;
	power_ctl_s pw;
	dev_state_e st;
	int errors = 0, total_checks = 0, cycles = 0, seen_cnt = 0, n;
	always #5 clk_sys_i = ~clk_sys_i;
	// Open-drain sync line with pull-up.
	assign sync_line = ~((sp_oe & ~sp_o) | peer_low);
	always @(posedge clk_sys_i) if (seen) seen_cnt++;
	// ============================================================
	// Instances
	// ============================================================
	led_mode_power_ctl #(.STARTUP_CYC(4), .EXT_GAP(50), .IDLE_LIMIT(3)) dut_u (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i), .supply_up_clear_i(supply_up_clear),
		.chip_power_pin_i(pwr_pin), .thermal_cutout_i(thermal), .reset_wr_i(reset_wr),
		.reset_wdata_i(reset_wd), .active_wr_i(active_wr), .active_wdata_i(active_wd),
		.run_ctl_wr_i(run_wr), .run_ctl_wdata_i(run_wd), .channel_behaviour_reg_i(beh),
		.onchip_osc_select_i(osc_sel), .clock_watch_on_i(watch),
		.auto_sleep_allow_i(allow), .pump_mode_i(pump), .aux_output_bit_i(aux_bit),
		.irq_out_bit_i(irq_bit), .irq_pin_as_output_i(irq_gpo), .stop_irq_i(stop_irq),
		.irq_clear_i(irq_clr), .look_i(look), .sync_send_i(sync_send),
		.sync_pulse_pin_i(sync_line), .slow_ref_clock_pin_i(ref_clk),
		.aux_output_o(aux_o), .irq_line_o(irq_o), .irq_line_oe_o(irq_oe),
		.sync_pulse_pin_o(sp_o), .sync_pulse_pin_oe_o(sp_oe), .sync_seen_o(seen),
		.slow_tick_o(tick), .outside_clock_active_flag_o(ext_flag),
		.device_active_bit_o(active), .run_ctl_o(run_o), .mode_slow_o(mode_o),
		.pc_clear_o(pc_clr), .chan_current_on_o(cur_on), .regs_default_o(regs_def),
		.bus_enabled_o(bus_en), .power_save_o(save), .power_o(pw), .state_o(st));
	sync_peer_model #(.HALF(20)) peer_u (.clk_sys_i(clk_sys_i), .run_clk_i(run_clk),
		.pull_req_i(pull_req), .pull_len_i(pull_len), .ref_clk_o(ref_clk),
		.pull_low_o(peer_low));
	// ============================================================
	// Tasks
	// ============================================================
	task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
		total_checks++;
		if (seen_v !== exp_v) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen_v, exp_v);
		end
	endtask
	task automatic wrap_up();
		$display("Checks made %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic write_active(input logic v);
		@(posedge clk_sys_i);
		active_wr <= 1;
		active_wd <= v;
		@(posedge clk_sys_i);
		active_wr <= 0;
		#1;
	endtask
	task automatic write_reset(input logic [7:0] v);
		@(posedge clk_sys_i);
		reset_wr <= 1;
		reset_wd <= v;
		@(posedge clk_sys_i);
		reset_wr <= 0;
		#1;
	endtask
	task automatic write_run(input logic [5:0] v);
		@(posedge clk_sys_i);
		run_wr <= 1;
		run_wd <= v;
		@(posedge clk_sys_i);
		run_wr <= 0;
		#1;
	endtask
	function automatic logic pick(input int w);
		return (w == 0) ? save : (w == 1) ? ext_flag : sp_oe;
	endfunction
	task automatic wait_until(input int w, input logic v);
		n = 0;
		while (pick(w) !== v && n < 20000) begin
			step(1);
			n++;
		end
	endtask
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 100000) begin
			errors++;
			wrap_up();
		end
	end
	// ============================================================
	// Sequence
	// ============================================================
	initial begin
		idle = '0;
		idle.pwm_zero = 1;
		idle.wait_long = 1;
		step(3);
		check(st, ST_RESET);
		check(pc_clr, 3'h7);
		@(posedge clk_sys_i);
		nrst_i <= 1;
		step(1);
		check(st, ST_STANDBY);
		check(active, 1'b0);
		@(posedge clk_sys_i);
		aux_bit <= 1;
		irq_gpo <= 1;
		irq_bit <= 1;
		step(1);
		check(aux_o, 1'b1);
		check({irq_oe, irq_o}, 2'h3);
		@(posedge clk_sys_i);
		irq_bit <= 0;
		aux_bit <= 0;
		irq_gpo <= 0;
		stop_irq <= 3'h2;
		@(posedge clk_sys_i);
		stop_irq <= 0;
		step(2);
		check(aux_o, 1'b0);
		check({irq_oe, irq_o}, 2'h2);
		@(posedge clk_sys_i);
		irq_clr <= 1;
		@(posedge clk_sys_i);
		irq_clr <= 0;
		step(2);
		check(irq_oe, 1'b0);
		write_run(6'h15);
		step(1);
		check(run_o, 6'h0);
		write_active(1);
		check({active, st}, {1'b1, ST_STARTUP});
		step(3);
		check(st, ST_STARTUP);
		step(1);
		check(st, ST_NORMAL);
		write_run(6'h15);
		step(1);
		check(run_o, 6'h15);
		@(posedge clk_sys_i);
		thermal <= 1;
		step(12);
		check(st, ST_STARTUP);
		@(posedge clk_sys_i);
		thermal <= 0;
		step(8);
		check(st, ST_NORMAL);
		check(ext_flag, 1'b0);
		check(pw, 5'h1f);
		// Outside clock under automatic selection.
		@(posedge clk_sys_i);
		run_clk <= 1;
		watch <= 1;
		beh <= 6'h28;
		wait_until(1, 1);
		check(ext_flag, 1'b1);
		step(120);
		check(mode_o, 6'h28);
		check({cur_on, pc_clr}, 6'h31);
		@(posedge clk_sys_i);
		look <= {NCH{idle}};
		step(600);
		check(save, 1'b0);
		@(posedge clk_sys_i);
		allow <= 1;
		wait_until(0, 1);
		check(save, 1'b1);
		check(pw, 5'h01);
		@(posedge clk_sys_i);
		run_clk <= 0;
		step(200);
		check(ext_flag, 1'b1);
		@(posedge clk_sys_i);
		run_clk <= 1;
		pump <= 2'h1;
		step(2);
		check(save, 1'b0);
		@(posedge clk_sys_i);
		pump <= 2'h3;
		wait_until(0, 1);
		check(save, 1'b1);
		@(posedge clk_sys_i);
		look[1].needs_pwm <= 1;
		wait_until(0, 0);
		check(save, 1'b0);
		@(posedge clk_sys_i);
		look <= '0;
		allow <= 0;
		sync_send <= 1;
		@(posedge clk_sys_i);
		sync_send <= 0;
		wait_until(2, 1);
		n = 0;
		while (sp_oe === 1'b1 && n < 3000) begin
			if (tick === 1'b1) seen_cnt = seen_cnt + 100;
			step(1);
			n++;
		end
		check(seen_cnt, 300);
		check(sync_line, 1'b1);
		seen_cnt = 0;
		@(posedge clk_sys_i);
		pull_req <= 1;
		pull_len <= 4'h1;
		@(posedge clk_sys_i);
		pull_req <= 0;
		step(400);
		check(seen_cnt, 0);
		@(posedge clk_sys_i);
		pull_req <= 1;
		pull_len <= 4'h3;
		@(posedge clk_sys_i);
		pull_req <= 0;
		step(400);
		check(seen_cnt, 1);
		@(posedge clk_sys_i);
		run_clk <= 0;
		wait_until(1, 0);
		check(ext_flag, 1'b0);
		@(posedge clk_sys_i);
		watch <= 0;
		osc_sel <= 0;
		step(2);
		check(ext_flag, 1'b1);
		@(posedge clk_sys_i);
		osc_sel <= 1;
		step(2);
		check(ext_flag, 1'b0);
		write_active(0);
		check({active, pc_clr}, 4'h7);
		write_active(1);
		step(6);
		@(posedge clk_sys_i);
		pwr_pin <= 0;
		step(2);
		check({active, pc_clr, bus_en}, 5'h0e);
		@(posedge clk_sys_i);
		pwr_pin <= 1;
		write_active(1);
		step(6);
		write_reset(8'hfe);
		step(1);
		check(active, 1'b1);
		write_reset(8'hff);
		check({regs_def, active}, 2'h2);
		step(3);
		check({st, active}, {ST_STANDBY, 1'b0});
		write_active(1);
		@(posedge clk_sys_i);
		supply_up_clear <= 1;
		step(2);
		check({st, active}, {ST_RESET, 1'b0});
		@(posedge clk_sys_i);
		supply_up_clear <= 0;
		step(2);
		check(st, ST_STANDBY);
		wrap_up();
	end
endmodule
`default_nettype wire
